// ===== shared/scpc_pkg.sv
// package: types and constants of the serdes channel port control block
package scpc_pkg;

	// ==========================================================
	// sizes
	localparam int NCH = 4;
	localparam int AW = 8;
	localparam int IRQ_W = 8;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h0c;

	// irq_stat / irq_mask field positions
	localparam int IRQ_CODE_ERR_LSB = 0;
	localparam int IRQ_TX_BUF_ERR_LSB = 4;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// receive timing selector codes
	localparam logic [1:0] RMODE_REF = 2'h0;
	localparam logic [1:0] RMODE_OWN = 2'h1;
	localparam logic [1:0] RMODE_CHA = 2'h2;

	// ==========================================================
	// control register, bit 0 upward: primary enables [3:0]
	typedef struct packed {
		logic codec_enable;
		logic ref_ratio_dual;
		logic [1:0] rx_timing_select;
		logic [NCH-1:0] loopback_select;
		logic [NCH-1:0] rx_input_select;
		logic [NCH-1:0] backup_tx_out_enable;
		logic [NCH-1:0] primary_tx_out_enable;
	} scpc_ctrl_t;
	localparam int CTRL_W = $bits(scpc_ctrl_t);
	localparam logic [CTRL_W-1:0] CTRL_RST = 20'h80000;

	// one decoded receive word from the deserializer and decoder
	typedef struct packed {
		logic rx_bit_nine;
		logic rx_bit_eight;
		logic [7:0] data;
		logic idle;
		logic kchar;
		logic code_err;
		logic comma_seen;
	} scpc_dec_t;

	// ==========================================================
	// whole state of the block
	typedef struct packed {
		scpc_ctrl_t ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [NCH-1:0][2:0] rclk_sync;
		logic [NCH-1:0] rclk_lvl;
		logic [2:0] ref_sync;
		logic ref_lvl;
		logic [NCH-1:0] rdiv;
		logic [NCH-1:0][7:0] rx_byte;
		logic [NCH-1:0] fill;
		logic [NCH-1:0] ctl;
		logic [NCH-1:0] err;
		logic [NCH-1:0] psd;
		logic [NCH-1:0] bsd;
		logic [NCH-1:0] tbe;
		logic [NCH-1:0] rclk_out;
		logic [NCH-1:0] rclk_out_inv;
		logic [NCH-1:0] ptx_out;
		logic [NCH-1:0] ptx_oe;
		logic [NCH-1:0] btx_out;
		logic [NCH-1:0] btx_oe;
		logic [NCH-1:0] serial_in;
		logic aw_held;
		logic [AW-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
	} scpc_state_t;

	localparam scpc_state_t ST_RST = '{
		ctrl: scpc_ctrl_t'(CTRL_RST),
		rclk_out_inv: 4'hf,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		default: '0
	};

endpackage

// ===== hdl/scpc_top.sv
// design: per-channel port control of a quad serial transceiver
// ==========================================================
// Function
// - primary serial output carries the tx stream while its enable is high
// - primary enable low powers down and undrives the primary outputs
// - backup outputs follow the backup enable the same way
// - received byte timed by recovered clock or reference clock per selector
// - fill flag high when decoder saw idle and it is on the byte
// - control flag high for a k character whose value is on the byte
// - code error flag marks invalid code or disparity; byte is then invalid
// - codec off: flags carry comma seen, bit eight and bit nine
// - recovered clock out from channel A or own, at 1/10 or 1/20 baud
// - unused recovered clock pair: true low, complement high
// - one timing selector for bytes, flags, signal detects, buffer errors
// - primary serial input used when loopback bit one low and select high
// - backup serial input used when loopback bit one low and select low
// - reference clock rising edge is the latch edge in reference timing
`timescale 1ns/1ps

module scpc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	// link side
	input wire logic ref_clk_a,
	input wire logic [3:0] recovered_clk_in,
	input wire scpc_pkg::scpc_dec_t [3:0] dec,
	input wire logic [3:0] analog_primary_detect,
	input wire logic [3:0] analog_backup_detect,
	input wire logic [3:0] tx_skew_overflow,
	input wire logic [3:0] tx_serial_stream,
	input wire logic [3:0] primary_serial_in,
	input wire logic [3:0] backup_serial_in,
	output logic [3:0] primary_serial_out,
	output logic [3:0] primary_serial_out_oe,
	output logic [3:0] backup_serial_out,
	output logic [3:0] backup_serial_out_oe,
	output logic [3:0] serial_rx_data,
	// parallel side
	output logic [3:0][7:0] rx_byte,
	output logic [3:0] fill_char_flag,
	output logic [3:0] control_char_flag,
	output logic [3:0] code_error_flag,
	output logic [3:0] primary_signal_detect,
	output logic [3:0] backup_signal_detect,
	output logic [3:0] tx_buffer_error,
	output logic [3:0] recovered_clk_out,
	output logic [3:0] recovered_clk_out_inv
);

	scpc_pkg::scpc_state_t st;
	scpc_pkg::scpc_state_t next_st;
	logic [3:0] rclk_lvl_new;
	logic [3:0] rclk_rise;
	logic ref_lvl_new;
	logic ref_rise;
	logic [3:0] tim_edge;

	// ==========================================================
	// edge finding on the sampled link clocks
	// a change counts once flops two and three agree, so one glitch
	// sample never makes an edge
	assign ref_lvl_new = (st.ref_sync[1] == st.ref_sync[2]) ?
		st.ref_sync[2] : st.ref_lvl;
	assign ref_rise = ref_lvl_new & ~st.ref_lvl;
	for (genvar g = 0; g < 4; g++) begin : g_edge
		assign rclk_lvl_new[g] = (st.rclk_sync[g][1] == st.rclk_sync[g][2]) ?
			st.rclk_sync[g][2] : st.rclk_lvl[g];
		assign rclk_rise[g] = rclk_lvl_new[g] & ~st.rclk_lvl[g];
		// one selector times every channel
		assign tim_edge[g] =
			(st.ctrl.rx_timing_select == scpc_pkg::RMODE_REF) ? ref_rise :
			(st.ctrl.rx_timing_select == scpc_pkg::RMODE_CHA) ? rclk_rise[0] :
			rclk_rise[g];
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] word;
		logic [31:0] rd;
		logic [scpc_pkg::IRQ_W-1:0] ev;
		logic src_lvl;
		logic src_rise;
		word = '0;
		rd = '0;
		ev = '0;
		src_lvl = 1'b0;
		src_rise = 1'b0;
		next_st = st;

		// link clock samplers; first flop feeds only the second
		next_st.ref_sync = {st.ref_sync[1:0], ref_clk_a};
		next_st.ref_lvl = ref_lvl_new;
		for (int i = 0; i < 4; i++) begin
			next_st.rclk_sync[i] = {st.rclk_sync[i][1:0], recovered_clk_in[i]};
			next_st.rclk_lvl[i] = rclk_lvl_new[i];
		end

		for (int i = 0; i < 4; i++) begin
			// serial outputs: undriven and held low while disabled
			next_st.ptx_oe[i] = st.ctrl.primary_tx_out_enable[i];
			next_st.ptx_out[i] = st.ctrl.primary_tx_out_enable[i] &
				tx_serial_stream[i];
			next_st.btx_oe[i] = st.ctrl.backup_tx_out_enable[i];
			next_st.btx_out[i] = st.ctrl.backup_tx_out_enable[i] &
				tx_serial_stream[i];

			// serial input source; loopback bit one takes the local stream
			if (st.ctrl.loopback_select[i]) begin
				next_st.serial_in[i] = tx_serial_stream[i];
			end else if (st.ctrl.rx_input_select[i]) begin
				next_st.serial_in[i] = primary_serial_in[i];
			end else begin
				next_st.serial_in[i] = backup_serial_in[i];
			end

			// byte, flags and status all move on one edge
			if (tim_edge[i]) begin
				next_st.rx_byte[i] = dec[i].data;
				if (st.ctrl.codec_enable) begin
					next_st.fill[i] = dec[i].idle;
					next_st.ctl[i] = dec[i].kchar;
					next_st.err[i] = dec[i].code_err;
				end else begin
					next_st.fill[i] = dec[i].comma_seen;
					next_st.ctl[i] = dec[i].rx_bit_eight;
					next_st.err[i] = dec[i].rx_bit_nine;
				end
				next_st.psd[i] = analog_primary_detect[i];
				next_st.bsd[i] = analog_backup_detect[i];
				next_st.tbe[i] = tx_skew_overflow[i];
				ev[scpc_pkg::IRQ_CODE_ERR_LSB+i] = st.ctrl.codec_enable &
					dec[i].code_err;
				ev[scpc_pkg::IRQ_TX_BUF_ERR_LSB+i] = tx_skew_overflow[i];
			end

			// recovered clock pair; halving gives the 1/20 rate
			src_lvl = (st.ctrl.rx_timing_select == scpc_pkg::RMODE_CHA) ?
				rclk_lvl_new[0] : rclk_lvl_new[i];
			src_rise = (st.ctrl.rx_timing_select == scpc_pkg::RMODE_CHA) ?
				rclk_rise[0] : rclk_rise[i];
			if (src_rise) begin
				next_st.rdiv[i] = ~st.rdiv[i];
			end
			if (st.ctrl.rx_timing_select == scpc_pkg::RMODE_REF) begin
				next_st.rclk_out[i] = 1'b0;
				next_st.rclk_out_inv[i] = 1'b1;
			end else begin
				next_st.rclk_out[i] = st.ctrl.ref_ratio_dual ?
					next_st.rdiv[i] : src_lvl;
				next_st.rclk_out_inv[i] = ~next_st.rclk_out[i];
			end
		end

		// write channel: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = scpc_pkg::RESP_OKAY;
			unique case (st.awaddr)
				scpc_pkg::OFF_CTRL: begin
					word = {12'h000, st.ctrl};
					for (int b = 0; b < 4; b++) begin
						if (st.wstrb[b]) begin
							word[b*8 +: 8] = st.wdata[b*8 +: 8];
						end
					end
					next_st.ctrl = scpc_pkg::scpc_ctrl_t'(word[19:0]);
				end
				scpc_pkg::OFF_IRQ_STAT: begin
					if (st.wstrb[0]) begin
						next_st.irq_stat = st.irq_stat & ~st.wdata[7:0];
					end
				end
				scpc_pkg::OFF_IRQ_MASK: begin
					if (st.wstrb[0]) begin
						next_st.irq_mask = st.wdata[7:0];
					end
				end
				scpc_pkg::OFF_STATUS: ;
				default: next_st.bresp = scpc_pkg::RESP_SLVERR;
			endcase
		end
		next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
		next_st.wready = ~next_st.w_held & ~next_st.bvalid;

		// read channel: one read at a time
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = scpc_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				scpc_pkg::OFF_CTRL: rd = {12'h000, st.ctrl};
				scpc_pkg::OFF_STATUS: rd = {16'h0000, st.psd, st.bsd,
					st.tbe, st.err};
				scpc_pkg::OFF_IRQ_STAT: rd = {24'h000000, st.irq_stat};
				scpc_pkg::OFF_IRQ_MASK: rd = {24'h000000, st.irq_mask};
				default: next_st.rresp = scpc_pkg::RESP_SLVERR;
			endcase
			next_st.rdata = rd;
		end

		// events set after the clear, so a same-cycle event survives
		next_st.irq_stat = next_st.irq_stat | ev;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
	end

	// ==========================================================
	// state register; clock enable low freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= scpc_pkg::ST_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs straight from the state
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign irq = st.irq;
	assign primary_serial_out = st.ptx_out;
	assign primary_serial_out_oe = st.ptx_oe;
	assign backup_serial_out = st.btx_out;
	assign backup_serial_out_oe = st.btx_oe;
	assign serial_rx_data = st.serial_in;
	assign rx_byte = st.rx_byte;
	assign fill_char_flag = st.fill;
	assign control_char_flag = st.ctl;
	assign code_error_flag = st.err;
	assign primary_signal_detect = st.psd;
	assign backup_signal_detect = st.bsd;
	assign tx_buffer_error = st.tbe;
	assign recovered_clk_out = st.rclk_out;
	assign recovered_clk_out_inv = st.rclk_out_inv;

	// ==========================================================
	// checks, channel 0 stands for all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ptx;
		ce |=> primary_serial_out_oe[0] ==
			$past(st.ctrl.primary_tx_out_enable[0]) &&
			primary_serial_out[0] == ($past(tx_serial_stream[0]) &
			primary_serial_out_oe[0]);
	endproperty
	a_ptx: assert property (p_ptx) else $error("primary tx wrong");

	property p_btx;
		ce && !st.ctrl.backup_tx_out_enable[0] |=>
			!backup_serial_out_oe[0] && !backup_serial_out[0];
	endproperty
	a_btx: assert property (p_btx) else $error("backup tx driven");

	property p_hold;
		ce && !tim_edge[0] |=> $stable(rx_byte[0]) &&
			$stable(code_error_flag[0]) && $stable(tx_buffer_error[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("byte moved off edge");

	property p_ref;
		ce && st.ctrl.rx_timing_select == scpc_pkg::RMODE_REF && ref_rise |=>
			rx_byte[0] == $past(dec[0].data);
	endproperty
	a_ref: assert property (p_ref) else $error("ref edge missed");

	property p_codec;
		ce && tim_edge[0] && st.ctrl.codec_enable |=>
			fill_char_flag[0] == $past(dec[0].idle) &&
			control_char_flag[0] == $past(dec[0].kchar) &&
			code_error_flag[0] == $past(dec[0].code_err);
	endproperty
	a_codec: assert property (p_codec) else $error("codec flags");

	property p_bypass;
		ce && tim_edge[0] && !st.ctrl.codec_enable |=>
			fill_char_flag[0] == $past(dec[0].comma_seen) &&
			control_char_flag[0] == $past(dec[0].rx_bit_eight) &&
			code_error_flag[0] == $past(dec[0].rx_bit_nine);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass flags");

	property p_unused;
		ce && st.ctrl.rx_timing_select == scpc_pkg::RMODE_REF |=>
			recovered_clk_out == 4'h0 && recovered_clk_out_inv == 4'hf;
	endproperty
	a_unused: assert property (p_unused) else $error("rclk not parked");

	property p_rclk;
		ce && st.ctrl.rx_timing_select == scpc_pkg::RMODE_OWN &&
			!st.ctrl.ref_ratio_dual |=> recovered_clk_out[0] ==
			st.rclk_lvl[0] && recovered_clk_out_inv[0] != recovered_clk_out[0];
	endproperty
	a_rclk: assert property (p_rclk) else $error("rclk source");

	property p_rxsel;
		ce && !st.ctrl.loopback_select[0] |=> serial_rx_data[0] ==
			($past(st.ctrl.rx_input_select[0]) ? $past(primary_serial_in[0]) :
			$past(backup_serial_in[0]));
	endproperty
	a_rxsel: assert property (p_rxsel) else $error("rx select");

	c_own: cover property (st.ctrl.rx_timing_select == scpc_pkg::RMODE_OWN
		&& tim_edge[1]);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property (irq);

endmodule // scpc_top

// ===== dv/scpc_far_model.sv
// far-side model: link clocks and a byte taker of user logic
`timescale 1ns/1ps

module scpc_far_model (
	input wire logic run_ref,
	input wire logic [3:0] run_rec,
	input wire logic [3:0] rclk_out,
	input wire logic [3:0] err_flag,
	output logic ref_clk,
	output logic [3:0] rec_clk,
	output int bad_cnt
);
	// ==========================================================
	// clocks
	initial begin
		ref_clk = 1'h0;
		rec_clk = 4'h0;
		bad_cnt = 0;
	end

	// 125 ns clocks; they stand low while stopped
	always #62.5 ref_clk <= run_ref & ~ref_clk;
	always #62.5 rec_clk <= run_rec & ~rec_clk;

	// ==========================================================
	// user logic
	// flagged bytes are dropped, never taken as data; the flag is
	// looked at mid-window so the byte update edge cannot race it
	always @(negedge rclk_out[0]) begin
		if (err_flag[0] === 1'h1) begin
			bad_cnt <= bad_cnt + 1;
		end
	end
endmodule // scpc_far_model

// ===== dv/tb_scpc_top.sv
// testbench of the serdes channel port control block
`timescale 1ns/1ps

module tb_scpc_top;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awv = 1'h0, awr, wv = 1'h0, wr_r, bv, br = 1'h0;
	logic arv = 1'h0, arr, rv, rr = 1'h0, irq;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] bresp, rresp;
	logic [3:0] pdet = 4'h0, bdet = 4'h0, skew = 4'h0, txs = 4'h0;
	logic [3:0] pin = 4'h0, bin = 4'h0, rec, run_rec = 4'h0;
	logic [3:0] po, poe, bo, boe, srx, fill, ctl, err, psd, bsd, tbe;
	logic [3:0] rco, rci;
	logic [3:0][7:0] rxb;
	logic refc, run_ref = 1'h0;
	logic [7:0] last = 8'h00;
	scpc_pkg::scpc_dec_t [3:0] dec = '0;
	int miscompares = 0;
	int n_checks = 0;
	int bad;

	// ==========================================================
	// clock, design and far side
	always #5 aclk = ~aclk;

	scpc_top u_dut (
		.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq),
		.ref_clk_a(refc), .recovered_clk_in(rec), .dec(dec),
		.analog_primary_detect(pdet), .analog_backup_detect(bdet),
		.tx_skew_overflow(skew), .tx_serial_stream(txs),
		.primary_serial_in(pin), .backup_serial_in(bin),
		.primary_serial_out(po), .primary_serial_out_oe(poe),
		.backup_serial_out(bo), .backup_serial_out_oe(boe),
		.serial_rx_data(srx), .rx_byte(rxb), .fill_char_flag(fill),
		.control_char_flag(ctl), .code_error_flag(err),
		.primary_signal_detect(psd), .backup_signal_detect(bsd),
		.tx_buffer_error(tbe), .recovered_clk_out(rco),
		.recovered_clk_out_inv(rci)
	);

	scpc_far_model u_far (
		.run_ref(run_ref), .run_rec(run_rec), .rclk_out(rco),
		.err_flag(err), .ref_clk(refc), .rec_clk(rec), .bad_cnt(bad)
	);

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// write: address and data offered together, bready held up
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		// only the watchdog ends a wait for the answer
		while (bv !== 1'h1) begin
			@(posedge aclk);
			if (awr === 1'h1)
				awv <= 1'h0;
			if (wr_r === 1'h1)
				wv <= 1'h0;
		end
		r = bresp;
		br <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		while (rv !== 1'h1) begin
			@(posedge aclk);
			if (arr === 1'h1)
				arv <= 1'h0;
		end
		d = rd;
		r = rresp;
		rr <= 1'h0;
		@(posedge aclk);
	endtask

	// bit eight and nine are the inverses, to tell them from the flags
	task automatic set_dec(input logic [7:0] b, input logic [3:0] f, k, e, c);
		for (int i = 0; i < 4; i++) begin
			dec[i] <= '{rx_bit_nine: ~e[i], rx_bit_eight: ~k[i],
				data: b + 8'(i), idle: f[i], kchar: k[i],
				code_err: e[i], comma_seen: c[i]};
		end
	endtask

	task automatic chk_rx(input logic [7:0] b, input logic [3:0] f, k, e);
		for (int i = 0; i < 4; i++)
			chk(rxb[i], b + 8'(i));
		chk(fill, f);
		chk(ctl, k);
		chk(err, e);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk({rci, rco}, 8'hf0);
		chk({poe, boe, po, bo}, 16'h0);
		wr(8'h10, 32'hffffffff, r);
		chk(r, scpc_pkg::RESP_SLVERR);
		rdr(8'h10, d, r);
		chk(r, scpc_pkg::RESP_SLVERR);
		rdr(scpc_pkg::OFF_CTRL, d, r);
		chk(d, 32'h80000);
	endtask

	task automatic t_tx();
		logic [1:0] r;
		wr(scpc_pkg::OFF_CTRL, 32'h800a5, r);
		for (int i = 0; i < 2; i++) begin
			txs <= (i == 0) ? 4'hf : 4'h6;
			repeat (4) @(posedge aclk);
			chk({poe, po}, {4'h5, txs & 4'h5});
			chk({boe, bo}, {4'ha, txs & 4'ha});
		end
	endtask

	task automatic rxs(input logic [3:0] s, l, p, b, e);
		logic [1:0] r;
		wr(scpc_pkg::OFF_CTRL, {16'h0008, l, s, 8'h00}, r);
		pin <= p;
		bin <= b;
		repeat (4) @(posedge aclk);
		chk(srx, e);
	endtask

	// the wrong clocks must not move the outputs, the right one must
	task automatic t_mode(input logic [1:0] m, input logic [4:0] no, ok,
		input logic [7:0] b);
		logic [1:0] r;
		int b0;
		{run_ref, run_rec} <= 5'h00;
		wr(scpc_pkg::OFF_CTRL, {12'h000, 2'h2, m, 16'h0000}, r);
		set_dec(b, 4'h1, 4'h2, 4'h5, 4'h0);
		pdet <= b[3:0];
		bdet <= ~b[3:0];
		skew <= b[7:4];
		{run_ref, run_rec} <= no;
		repeat (40) @(posedge aclk);
		chk(rxb[0], last);
		b0 = bad;
		{run_ref, run_rec} <= ok;
		repeat (40) @(posedge aclk);
		chk_rx(b, 4'h1, 4'h2, 4'h5);
		// far side drops flagged bytes only while the clock pair runs
		chk(logic'(bad != b0), logic'(m != 2'h0));
		chk({psd, bsd, tbe}, {b[3:0], ~b[3:0], b[7:4]});
		last = b;
	endtask

	task automatic t_codec_off();
		logic [1:0] r;
		wr(scpc_pkg::OFF_CTRL, 32'h10000, r);
		set_dec(8'h80, 4'h5, 4'h3, 4'h6, 4'h9);
		{run_ref, run_rec} <= 5'h0f;
		repeat (40) @(posedge aclk);
		chk_rx(8'h80, 4'h9, 4'hc, 4'h9);
	endtask

	task automatic rises(input int c, output int n);
		logic p;
		n = 0;
		p = rco[c];
		repeat (100) begin
			@(posedge aclk);
			chk(rci[c] ^ rco[c], 1'h1);
			n += int'(rco[c] === 1'h1 && p === 1'h0);
			p = rco[c];
		end
	endtask

	// 100 cycles hold eight link periods
	task automatic t_rclk();
		logic [1:0] r;
		int n;
		{run_ref, run_rec} <= 5'h1f;
		wr(scpc_pkg::OFF_CTRL, 32'h80000, r);
		rises(1, n);
		chk({rco, 28'(n)}, 32'h0);
		wr(scpc_pkg::OFF_CTRL, 32'h90000, r);
		rises(1, n);
		chk(logic'(n inside {[7:9]}), 1'h1);
		wr(scpc_pkg::OFF_CTRL, 32'hd0000, r);
		rises(2, n);
		chk(logic'(n inside {[3:5]}), 1'h1);
		{run_ref, run_rec} <= 5'h01;
		wr(scpc_pkg::OFF_CTRL, 32'ha0000, r);
		rises(3, n);
		chk(logic'(n inside {[7:9]}), 1'h1);
	endtask

	// sticky bits: error on ch0 and ch2, overflow on ch1; only ch2 unmasked
	task automatic t_irq();
		logic [31:0] d;
		logic [1:0] r;
		wr(scpc_pkg::OFF_CTRL, 32'h80000, r);
		{run_ref, run_rec} <= 5'h10;
		set_dec(8'h00, 4'h0, 4'h0, 4'h0, 4'h0);
		skew <= 4'h0;
		repeat (40) @(posedge aclk);
		wr(scpc_pkg::OFF_IRQ_STAT, 32'hff, r);
		wr(scpc_pkg::OFF_IRQ_MASK, 32'h04, r);
		chk(irq, 1'h0);
		set_dec(8'h00, 4'h0, 4'h0, 4'h5, 4'h0);
		skew <= 4'h2;
		repeat (40) @(posedge aclk);
		chk(irq, 1'h1);
		rdr(scpc_pkg::OFF_IRQ_STAT, d, r);
		chk(d, 32'h25);
		set_dec(8'h00, 4'h0, 4'h0, 4'h0, 4'h0);
		skew <= 4'h0;
		repeat (40) @(posedge aclk);
		wr(scpc_pkg::OFF_IRQ_STAT, 32'h04, r);
		repeat (2) @(posedge aclk);
		chk(irq, 1'h0);
		rdr(scpc_pkg::OFF_IRQ_STAT, d, r);
		chk(d, 32'h21);
	endtask

	// ==========================================================
	// run and verdict
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_tx();
		rxs(4'h3, 4'h0, 4'hf, 4'h0, 4'h3);
		rxs(4'h3, 4'h0, 4'h0, 4'hf, 4'hc);
		rxs(4'hf, 4'h1, 4'hf, 4'h0, 4'he);
		t_mode(2'h0, 5'h0f, 5'h10, 8'h20);
		t_mode(2'h1, 5'h10, 5'h0f, 8'h40);
		t_mode(2'h2, 5'h1e, 5'h01, 8'h60);
		t_mode(2'h3, 5'h10, 5'h0f, 8'h80);
		t_codec_off();
		t_rclk();
		t_irq();
		end_of_test();
	end

	// hang guard, far beyond the thousand or so cycles of the run
	initial begin
		#300000;
		miscompares++;
		end_of_test();
	end
endmodule // tb_scpc_top
